/* File: design/pfi_ident.sv */
`timescale 1ns/100ps
`default_nettype none
`include "pfi_map.svh"

module pfi_ident #(
	parameter logic [7:0] EXT_FAMILY = 8'h06,
	parameter logic [3:0] BASE_FAMILY = 4'hf,
	parameter logic [3:0] EXT_MODEL = 4'h6,
	parameter logic [3:0] BASE_MODEL = 4'h0,
	parameter logic [3:0] STEPPING = 4'h1,
	parameter logic [31:0] VENDOR_B = 32'h5844_4c50, // Arbitrary value
	parameter logic [31:0] VENDOR_C = 32'h5844_4c50, // Arbitrary value
	parameter logic [31:0] VENDOR_D = 32'h5844_4c50, // Arbitrary value
	parameter bit PROD_CRYPTO = 1'b1,
	parameter bit PROD_CARRYLESS = 1'b1
)(
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic query_valid,
	input wire logic [31:0] query_function,
	input wire logic [31:0] query_subfunction,
	input wire logic [7:0] initial_interrupt_ctrl_id,
	input wire logic [7:0] core_count_minus_one,
	input wire logic monitor_wait_disable,
	input wire logic interrupt_ctrl_global_enable,
	input wire logic os_extended_state_enabled,
	input wire logic override_wr_en,
	input wire logic override_wr_sel_d,
	input wire logic [31:0] override_wr_data,
	output logic [31:0] override_c_rd,
	output logic [31:0] override_d_rd,
	output logic result_valid,
	output logic [31:0] result_a,
	output logic [31:0] result_b,
	output logic [31:0] result_c,
	output logic [31:0] result_d,
	output logic [7:0] family_out,
	output logic [7:0] model_out
);

	// ****************
	// Parameter checks
	// ****************
	// The computed family must fit its 8-bit output
	if (int'(BASE_FAMILY) + int'(EXT_FAMILY) > 255)
	begin : g_family_check
		$error("family parameters overflow eight bits");
	end

	// ****************
	// Override register
	// ****************
	logic [31:0] ovr_c_q;
	logic [31:0] ovr_d_q;
	pfi_pkg::pfi_state_t state_q;

	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			ovr_c_q <= `PFI_C_DEFAULT;
			ovr_d_q <= `PFI_D_DEFAULT;
		end
		else if (override_wr_en)
		begin
			if (override_wr_sel_d)
				ovr_d_q <= override_wr_data;
			else
				ovr_c_q <= override_wr_data;
		end
	end

	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			override_c_rd <= 32'h0000_0000;
			override_d_rd <= 32'h0000_0000;
		end
		else
		begin
			override_c_rd <= ovr_c_q;
			override_d_rd <= ovr_d_q;
		end
	end

	// ****************
	// Word assembly
	// ****************
	function automatic logic [31:0] word_c_f(input logic [31:0] ovr, input logic mwd,
		input logic osx);
		logic [31:0] w;
		w = ovr;
		w[`PFI_C_GUEST_BIT] = 1'b0;
		w[`PFI_C_MONITOR_BIT] = ~mwd;
		w[`PFI_C_OSXSTATE_BIT] = osx;
		w[`PFI_C_XIRQ_BIT] = 1'b0;
		w[`PFI_C_PCID_BIT] = 1'b0;
		w[`PFI_C_CRYPTO_BIT] = PROD_CRYPTO;
		w[`PFI_C_CARRYLESS_BIT] = PROD_CARRYLESS;
		return w;
	endfunction

	logic [31:0] a_d, b_d, c_d, d_d;
	logic [7:0] cores;

	always_comb
	begin
		cores = core_count_minus_one + 8'h01;
		a_d = 32'h0000_0000;
		b_d = 32'h0000_0000;
		c_d = 32'h0000_0000;
		d_d = 32'h0000_0000;
		if (query_function == `PFI_FN_VENDOR)
		begin
			a_d = `PFI_MAX_STD_FN;
			b_d = VENDOR_B;
			c_d = VENDOR_C;
			d_d = VENDOR_D;
		end
		else if (query_function == `PFI_FN_FEATURE)
		begin
			a_d[`PFI_A_EFAM_LSB +: 8] = EXT_FAMILY;
			a_d[`PFI_A_EMODEL_LSB +: 4] = EXT_MODEL;
			a_d[`PFI_A_BFAM_LSB +: 4] = BASE_FAMILY;
			a_d[`PFI_A_BMODEL_LSB +: 4] = BASE_MODEL;
			a_d[`PFI_A_STEP_LSB +: 4] = STEPPING;
			b_d[`PFI_B_IRQID_LSB +: 8] = initial_interrupt_ctrl_id;
			b_d[`PFI_B_CORES_LSB +: 8] = cores;
			b_d[`PFI_B_FLUSH_LSB +: 8] = `PFI_LINE_FLUSH_QW;
			c_d = word_c_f(ovr_c_q, monitor_wait_disable, os_extended_state_enabled);
			d_d = ovr_d_q;
			d_d[`PFI_D_MULTI_BIT] = (core_count_minus_one != 8'h00);
			d_d[`PFI_D_IRQEN_BIT] = interrupt_ctrl_global_enable;
		end
		else if (query_function == `PFI_FN_MONITOR)
		begin
			a_d[15:0] = `PFI_MON_LINE_BYTES;
			b_d[15:0] = `PFI_MON_LINE_BYTES;
			c_d = `PFI_MON_EXT_WORD;
		end
		else if (query_function == `PFI_FN_POWER)
		begin
			a_d = `PFI_PWR_TIMER_WORD;
			c_d = `PFI_PWR_ECX_WORD;
		end
		// Functions two to four fall through as zero
	end

	// ****************
	// Result registers
	// ****************
	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
			state_q <= pfi_pkg::PFI_IDLE;
		else
			state_q <= query_valid ? pfi_pkg::PFI_BUSY : pfi_pkg::PFI_IDLE;
	end

	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			result_valid <= 1'b0;
			result_a <= 32'h0000_0000;
			result_b <= 32'h0000_0000;
			result_c <= 32'h0000_0000;
			result_d <= 32'h0000_0000;
		end
		else
		begin
			result_valid <= query_valid;
			if (query_valid)
			begin
				result_a <= a_d;
				result_b <= b_d;
				result_c <= c_d;
				result_d <= d_d;
			end
		end
	end

	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			family_out <= 8'h00;
			model_out <= 8'h00;
		end
		else
		begin
			family_out <= {4'h0, BASE_FAMILY} + EXT_FAMILY;
			model_out <= {EXT_MODEL, BASE_MODEL};
		end
	end

	// ****************
	// Assertions
	// ****************
	logic unused_sub;
	assign unused_sub = ^query_subfunction;

	a_undef_zero: assert property (@(posedge sys_clk) disable iff (!rst_n)
		query_valid && query_function > `PFI_MAX_STD_FN |=> result_a == 32'h0 && result_d == 32'h0)
		else $error("undefined function not zero");
	a_max_fn: assert property (@(posedge sys_clk) disable iff (!rst_n)
		query_valid && query_function == `PFI_FN_VENDOR |=> result_a == 32'h0000_000d)
		else $error("max function wrong");
	a_guest_zero: assert property (@(posedge sys_clk) disable iff (!rst_n)
		query_valid && query_function == `PFI_FN_FEATURE |=> !result_c[31] && !result_c[21])
		else $error("reserved feature bit set");
	a_monitor_inv: assert property (@(posedge sys_clk) disable iff (!rst_n)
		query_valid && query_function == `PFI_FN_FEATURE |=> result_c[3] == !$past(monitor_wait_disable))
		else $error("monitor flag wrong");
	a_multi_core: assert property (@(posedge sys_clk) disable iff (!rst_n)
		query_valid && query_function == `PFI_FN_FEATURE
		|=> result_d[28] == ($past(core_count_minus_one) != 8'h00)
		&& result_b[23:16] == $past(core_count_minus_one) + 8'h01)
		else $error("core count wrong");
	a_irq_enable: assert property (@(posedge sys_clk) disable iff (!rst_n)
		query_valid && query_function == `PFI_FN_FEATURE
		|=> result_d[9] == $past(interrupt_ctrl_global_enable) && result_b[15:8] == 8'h08)
		else $error("enable flag wrong");
	a_mon_lines: assert property (@(posedge sys_clk) disable iff (!rst_n)
		query_valid && query_function == `PFI_FN_MONITOR |=> result_a == 32'h40 && result_c == 32'h3)
		else $error("monitor sizes wrong");
	a_rsvd_fns: assert property (@(posedge sys_clk) disable iff (!rst_n)
		query_valid && query_function >= 32'h2 && query_function <= 32'h4
		|=> (result_a | result_b | result_c | result_d) == 32'h0)
		else $error("reserved function nonzero");
	a_timer_always_running: assert property (@(posedge sys_clk) disable iff (!rst_n)
		query_valid && query_function == `PFI_FN_POWER |=> result_a == 32'h4)
		else $error("timer flag wrong");
	a_vendor_words: assert property (@(posedge sys_clk) disable iff (!rst_n)
		query_valid && query_function == `PFI_FN_VENDOR
		|=> result_b == VENDOR_B && result_c == VENDOR_C && result_d == VENDOR_D)
		else $error("vendor words wrong");
	a_fms_layout: assert property (@(posedge sys_clk) disable iff (!rst_n)
		query_valid && query_function == `PFI_FN_FEATURE
		|=> result_a[27:20] == EXT_FAMILY && result_a[19:16] == EXT_MODEL
		&& result_a[11:8] == BASE_FAMILY && result_a[7:4] == BASE_MODEL
		&& result_a[3:0] == STEPPING && result_a[31:28] == 4'h0 && result_a[15:12] == 4'h0)
		else $error("family model stepping layout wrong");
	a_irq_id: assert property (@(posedge sys_clk) disable iff (!rst_n)
		query_valid && query_function == `PFI_FN_FEATURE
		|=> result_b[31:24] == $past(initial_interrupt_ctrl_id) && result_b[7:0] == 8'h00)
		else $error("interrupt id wrong");
	a_os_state: assert property (@(posedge sys_clk) disable iff (!rst_n)
		query_valid && query_function == `PFI_FN_FEATURE
		|=> result_c[27] == $past(os_extended_state_enabled) && !result_c[17])
		else $error("extended state flag wrong");
	a_product_bits: assert property (@(posedge sys_clk) disable iff (!rst_n)
		query_valid && query_function == `PFI_FN_FEATURE
		|=> result_c[25] == PROD_CRYPTO && result_c[1] == PROD_CARRYLESS)
		else $error("product feature bits wrong");
	a_mon_rsvd: assert property (@(posedge sys_clk) disable iff (!rst_n)
		query_valid && query_function == `PFI_FN_MONITOR
		|=> result_b == 32'h40 && result_d == 32'h0)
		else $error("monitor reserved bits set");
	a_answer_time: assert property (@(posedge sys_clk) disable iff (!rst_n)
		query_valid |=> result_valid && state_q == pfi_pkg::PFI_BUSY)
		else $error("answer not one cycle after query");
	a_family_calc: assert property (@(posedge sys_clk) disable iff (!rst_n)
		family_out == {4'h0, BASE_FAMILY} + EXT_FAMILY || $past(!rst_n))
		else $error("family wrong");
	c_monitor: cover property (@(posedge sys_clk) query_valid && query_function == 32'h5);
	c_back_to_back: cover property (@(posedge sys_clk) query_valid ##1 query_valid);
	c_feature: cover property (@(posedge sys_clk) query_valid && query_function == 32'h1);
	c_vendor: cover property (@(posedge sys_clk) query_valid && query_function == 32'h0);
	c_override: cover property (@(posedge sys_clk) override_wr_en ##1 query_valid);

endmodule // pfi_ident

`default_nettype wire

/* File: design/pfi_map.svh */
`ifndef PFI_MAP_SVH
`define PFI_MAP_SVH

// Function numbers
`define PFI_FN_VENDOR 32'h0000_0000
`define PFI_FN_FEATURE 32'h0000_0001
`define PFI_FN_RSVD_LO 32'h0000_0002
`define PFI_FN_RSVD_HI 32'h0000_0004
`define PFI_FN_MONITOR 32'h0000_0005
`define PFI_FN_POWER 32'h0000_0006
`define PFI_MAX_STD_FN 32'h0000_000d

// Function one, word A fields
`define PFI_A_STEP_LSB 0
`define PFI_A_BMODEL_LSB 4
`define PFI_A_BFAM_LSB 8
`define PFI_A_EMODEL_LSB 16
`define PFI_A_EFAM_LSB 20

// Function one, word B fields
`define PFI_B_FLUSH_LSB 8
`define PFI_B_CORES_LSB 16
`define PFI_B_IRQID_LSB 24
`define PFI_LINE_FLUSH_QW 8'h08

// Feature flag positions
`define PFI_C_MONITOR_BIT 3
`define PFI_C_CARRYLESS_BIT 1
`define PFI_C_PCID_BIT 17
`define PFI_C_XIRQ_BIT 21
`define PFI_C_CRYPTO_BIT 25
`define PFI_C_OSXSTATE_BIT 27
`define PFI_C_GUEST_BIT 31
`define PFI_D_IRQEN_BIT 9
`define PFI_D_MULTI_BIT 28

// Override reset values: fixed flags, live bits cleared except C bit 27 and D bit 9, which reset set
`define PFI_C_DEFAULT 32'h7cd8_3201
`define PFI_D_DEFAULT 32'h07d8_fbff

// Functions five and six
`define PFI_MON_LINE_BYTES 16'h0040
`define PFI_MON_EXT_WORD 32'h0000_0003
`define PFI_PWR_TIMER_WORD 32'h0000_0004
`define PFI_PWR_ECX_WORD 32'h0000_0001

`endif

/* File: design/pfi_pkg.sv */
package pfi_pkg;
	typedef enum logic [1:0]
	{
		PFI_IDLE = 2'b00,
		PFI_BUSY = 2'b01
	} pfi_state_t;
endpackage

/* File: verif/pfi_requester.sv */
`timescale 1ns/100ps
`default_nettype none

// ****************************************
// Query issuer, driven off the falling edge
// ****************************************
module pfi_requester (
	output logic query_valid,
	output logic [31:0] query_function,
	output logic [31:0] query_subfunction
);
	initial
	begin
		query_valid = 1'b0;
		query_function = 32'h0000_0000;
		query_subfunction = 32'h0000_0000;
	end

	// Idle cycles invert the function lines so nothing stale looks valid
	task automatic issue(input bit go, input logic [31:0] fn);
	begin
		query_valid = go;
		query_function = go ? fn : ~query_function;
		query_subfunction = $urandom;
	end
	endtask
endmodule // pfi_requester

`default_nettype wire

/* File: verif/pfi_ident_test.sv */
`timescale 1ns/100ps
`default_nettype none
`include "pfi_map.svh"
`define CHK(n, e, g) begin samples_checked++; if ((g) !== (e)) begin n_fail++; \
	$display("BAD %s exp %h got %h", n, e, g); end end

module pfi_ident_test;
	localparam logic [31:0] VND = 32'h5844_4c50; // Arbitrary value
	logic sys_clk = 1'b0;
	logic rst_n = 1'b0;
	logic mwd = 1'b0;
	logic ien = 1'b0;
	logic osx = 1'b0;
	logic wen = 1'b0;
	logic wsel = 1'b0;
	logic [7:0] iid = 8'h00;
	logic [7:0] ccm = 8'h00;
	logic [31:0] wdat = 32'h0000_0000;
	logic [31:0] ovc = `PFI_C_DEFAULT;
	logic [31:0] ovd = `PFI_D_DEFAULT;
	logic [31:0] oc, od, ra, rb, rc, rd, qf, qs;
	logic qv, rv;
	logic [7:0] fam, mdl;
	logic [127:0] ew [2] = '{128'h0, 128'h0};
	logic evv [2] = '{1'b0, 1'b0};
	logic [127:0] last = 128'h0;
	logic [31:0] corner [4] = '{32'h0000_000d, 32'h8000_0000, 32'hffff_ffff, 32'h0000_0007};
	int quiet = 0;
	int n_fail = 0;
	int samples_checked = 0;

	always #20 sys_clk = ~sys_clk;

	pfi_requester req (.query_valid(qv), .query_function(qf), .query_subfunction(qs));

	pfi_ident dut (.sys_clk(sys_clk), .rst_n(rst_n), .query_valid(qv), .query_function(qf),
		.query_subfunction(qs), .initial_interrupt_ctrl_id(iid), .core_count_minus_one(ccm),
		.monitor_wait_disable(mwd), .interrupt_ctrl_global_enable(ien),
		.os_extended_state_enabled(osx), .override_wr_en(wen), .override_wr_sel_d(wsel),
		.override_wr_data(wdat), .override_c_rd(oc), .override_d_rd(od), .result_valid(rv),
		.result_a(ra), .result_b(rb), .result_c(rc), .result_d(rd), .family_out(fam),
		.model_out(mdl));

	// ****************************************
	// Expected words for one query
	// ****************************************
	function automatic logic [127:0] expect_words(input logic [31:0] fn);
		logic [31:0] c;
		logic [31:0] d;
		c = ovc;
		d = ovd;
		c[31] = 1'b0;
		c[27] = osx;
		c[21] = 1'b0;
		c[17] = 1'b0;
		c[25] = 1'b1;
		c[1] = 1'b1;
		c[3] = ~mwd;
		d[28] = |ccm;
		d[9] = ien;
		case (fn)
			32'h0000_0000: return {32'h0000_000d, VND, VND, VND};
			32'h0000_0001: return {32'h0066_0f01, iid, ccm + 8'h01, 8'h08, 8'h00, c, d};
			32'h0000_0005: return {32'h0000_0040, 32'h0000_0040, 32'h0000_0003, 32'h0000_0000};
			32'h0000_0006: return {32'h0000_0004, 32'h0000_0000, 32'h0000_0001, 32'h0000_0000};
			default: return 128'h0;
		endcase
	endfunction

	task automatic step(input int i);
		int r;
		logic [31:0] fn;
		`CHK("result_valid", evv[0], rv)
		if (evv[0])
		begin
			last = ew[0];
		end
		`CHK("words", last, {ra, rb, rc, rd})
		if (quiet > 2)
		begin
			`CHK("override", {ovc, ovd}, {oc, od})
		end
		iid = $urandom;
		ccm = $urandom % 4;
		{mwd, ien, osx} = $urandom;
		wen = 1'b0;
		r = (i < 4) ? 2 : $urandom % 4;
		fn = (i < 4) ? corner[i] : (($urandom % 3 == 0) ? $urandom : $urandom % 8);
		quiet++;
		if (r == 0)
		begin
			wen = 1'b1;
			wsel = $urandom;
			wdat = $urandom;
			quiet = 0;
			if (wsel)
				ovd = wdat;
			else
				ovc = wdat;
		end
		req.issue(r > 1, fn);
		evv[0] = (r > 1);
		ew[0] = expect_words(fn);
	endtask

	task automatic summarize;
		$display("checks %0d mismatches %0d", samples_checked, n_fail);
		if (n_fail == 0 && samples_checked > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	initial
	begin
		void'($urandom(1308));
		repeat (5) @(negedge sys_clk);
		rst_n = 1'b1;
		@(negedge sys_clk);
		`CHK("override", {`PFI_C_DEFAULT, `PFI_D_DEFAULT}, {oc, od})
		`CHK("family", 8'h06 + {4'h0, 4'hf}, fam)
		`CHK("model", {4'h6, 4'h0}, mdl)
		$display("test reset done");
		for (int i = 0; i < 400; i++)
		begin
			@(negedge sys_clk);
			step(i);
		end
		$display("test random done");
		summarize();
	end
endmodule // pfi_ident_test

`default_nettype wire
